// ===== include/dac_regs_pkg.sv
package dac_regs_pkg;

    // command frame layout
    localparam logic [4:0] FRAME_BITS      = 5'h18;
    localparam int         RW_BIT          = 23;
    localparam int         ADDR_HI         = 22;
    localparam int         ADDR_LO         = 20;
    localparam int         DATA_HI         = 19;
    localparam int         DATA_LO         = 4;
    localparam logic       RW_WRITE        = 1'h0;
    localparam logic       RW_READ         = 1'h1;

    // register addresses
    localparam logic [2:0] ADDR_DAC_DATA   = 3'h1;
    localparam logic [2:0] ADDR_CONTROL    = 3'h2;
    localparam logic [2:0] ADDR_CLEAR_VAL  = 3'h3;
    localparam logic [2:0] ADDR_SOFT_ACT   = 3'h4;

    // control register: frame bits 5..1 kept as a 5-bit field
    localparam int         CTRL_HI         = 5;
    localparam int         CTRL_LO         = 1;
    localparam int         CTRL_SDO_DIS    = 4;
    localparam int         CTRL_CODING     = 3;
    localparam logic [4:0] CTRL_RESET      = 5'h07;
    localparam logic       CODING_TWOS     = 1'h0;

    // software action bits
    localparam int         SOFT_RESET_BIT  = 2;
    localparam int         SOFT_CLEAR_BIT  = 1;
    localparam int         SOFT_LOAD_BIT   = 0;

    // data register reset values and coding msb flip mask
    localparam logic [15:0] DAC_RESET      = 16'h0000;
    localparam logic [15:0] CLEAR_RESET    = 16'h0000;
    localparam logic [15:0] MSB_FLIP       = 16'h8000;

    // pin synchroniser lanes
    localparam int         PIN_SYNC_N      = 0;
    localparam int         PIN_LOAD_N      = 1;
    localparam int         PIN_CLEAR_N     = 2;
    localparam logic [2:0] PINS_IDLE       = 3'h7;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic       sync_n_prev;
    } pin_sync_t;

    typedef struct packed {
        pin_sync_t   pins;
        logic [15:0] pending;
        logic [15:0] active;
        logic [15:0] clear_value;
        logic [4:0]  ctrl;
        logic [23:0] read_word;
        logic [15:0] dac_code;
        logic        update;
        logic        sdo_oe;
        logic        coding;
    } sys_state_t;

    typedef struct packed {
        logic [23:0] shift;
        logic        full;
    } link_state_t;

endpackage

// ===== rtl/dac_soft_regs.sv
`timescale 1ns/100ps
// Function
// [R01] coding select 0 (reset) means twos complement, 1 means offset binary.
// [R02] serial output driven when disable bit is 0, high impedance when 1; the code drives it only while the frame signal is low.
// [R03] frame msb selects direction: 0 write, 1 read.
// [R04] clear value frame carries 16 bits in 19..4, low four ignored.
// [R05] action register is write only; a 1 acts like a low pin pulse.
// [R06] action frame address 100: bit2 reset, bit1 clear, bit0 load.
// [R07] software clear ignored while load pin is held low.
// [R08] software load ignored while clear pin is held low.
// [R09] software load moves pending value into active register and output.
// [R10] software clear copies clear value into dac register under current coding.
// [R11] software reset returns every register to its power-on value.
// [R12] data frame address 001 carries 16 bits in 19..4, low four ignored.
// [R13] host writes zeros to reserved action bits.
module dac_soft_regs (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        serial_clk_in,
    input  wire logic        frame_sync_n_in,
    input  wire logic        serial_data_in,
    input  wire logic        load_output_n_in,
    input  wire logic        clear_to_code_n_in,
    output logic             serial_data_out,
    output logic             serial_data_oe_out,
    output logic [15:0]      dac_code_out,
    output logic             dac_update_out,
    output logic             coding_select_out
);

    dac_regs_pkg::sys_state_t  sys_q;
    dac_regs_pkg::sys_state_t  sys_d;
    dac_regs_pkg::link_state_t link_q;
    dac_regs_pkg::link_state_t link_d;
    logic [4:0]                cnt_q;
    logic [4:0]                cnt_d;
    logic                      sdo_q;
    logic                      sdo_d;
    logic                      frame_rst;

    // converter code shown during reset: zero in twos complement coding
    localparam logic [15:0] DAC_CODE_AT_RESET = dac_regs_pkg::DAC_RESET ^ dac_regs_pkg::MSB_FLIP;

    // link side: the serial clock only runs inside a frame, so the bit counter
    // and the output bit are cleared by the frame signal itself
    assign frame_rst = sys_rst_in | frame_sync_n_in;

    always_comb begin
        link_d       = link_q;
        link_d.shift = {link_q.shift[22:0], serial_data_in};
        link_d.full  = (cnt_q >= dac_regs_pkg::FRAME_BITS - 5'h01);
        cnt_d        = (cnt_q == dac_regs_pkg::FRAME_BITS) ? cnt_q : cnt_q + 5'h01;
    end

    // read word is only rewritten after a frame ends, so it is static here
    always_comb begin
        sdo_d = 1'b0;
        if (cnt_q != 5'h00 && cnt_q <= dac_regs_pkg::FRAME_BITS) begin
            sdo_d = sys_q.read_word[dac_regs_pkg::FRAME_BITS - cnt_q];
        end
    end

    always_ff @(posedge serial_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    always_ff @(posedge serial_clk_in or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(negedge serial_clk_in or posedge frame_rst) begin
        if (frame_rst) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= sdo_d;
        end
    end

    // system side
    always_comb begin
        logic        frame_end;
        logic [23:0] w;
        logic [2:0]  addr;
        logic [15:0] data;
        logic        load_pin_low;
        logic        clear_pin_low;
        logic        soft_clear;
        logic        soft_load;
        frame_end     = 1'b0;
        w             = link_q.shift;
        addr          = w[dac_regs_pkg::ADDR_HI:dac_regs_pkg::ADDR_LO];
        data          = w[dac_regs_pkg::DATA_HI:dac_regs_pkg::DATA_LO];
        load_pin_low  = ~sys_q.pins.sync[dac_regs_pkg::PIN_LOAD_N];
        clear_pin_low = ~sys_q.pins.sync[dac_regs_pkg::PIN_CLEAR_N];
        soft_clear    = 1'b0;
        soft_load     = 1'b0;

        sys_d                  = sys_q;
        sys_d.update           = 1'b0;
        sys_d.pins.meta        = {clear_to_code_n_in, load_output_n_in, frame_sync_n_in};
        sys_d.pins.sync        = sys_q.pins.meta;
        sys_d.pins.sync_n_prev = sys_q.pins.sync[dac_regs_pkg::PIN_SYNC_N];
        frame_end = sys_q.pins.sync[dac_regs_pkg::PIN_SYNC_N] & ~sys_q.pins.sync_n_prev & link_q.full;

        if (frame_end && w[dac_regs_pkg::RW_BIT] == dac_regs_pkg::RW_WRITE) begin // [R03]
            unique case (addr)
                dac_regs_pkg::ADDR_DAC_DATA:  sys_d.pending = data; // [R12]
                dac_regs_pkg::ADDR_CONTROL:   sys_d.ctrl = w[dac_regs_pkg::CTRL_HI:dac_regs_pkg::CTRL_LO];
                dac_regs_pkg::ADDR_CLEAR_VAL: sys_d.clear_value = data; // [R04]
                dac_regs_pkg::ADDR_SOFT_ACT: begin
                    // reserved bits 19..3 are not looked at [R06] [R13]
                    soft_clear = w[dac_regs_pkg::SOFT_CLEAR_BIT] & ~load_pin_low; // [R05] [R07]
                    soft_load  = w[dac_regs_pkg::SOFT_LOAD_BIT] & ~clear_pin_low; // [R05] [R08]
                end
                default: ;
            endcase
        end else if (frame_end) begin
            // action register reads back as zero: it holds nothing [R05]
            sys_d.read_word = '0;
            sys_d.read_word[dac_regs_pkg::RW_BIT] = dac_regs_pkg::RW_READ; // [R03]
            sys_d.read_word[dac_regs_pkg::ADDR_HI:dac_regs_pkg::ADDR_LO] = addr;
            unique case (addr)
                dac_regs_pkg::ADDR_DAC_DATA:
                    sys_d.read_word[dac_regs_pkg::DATA_HI:dac_regs_pkg::DATA_LO] = sys_q.pending;
                dac_regs_pkg::ADDR_CONTROL:
                    sys_d.read_word[dac_regs_pkg::CTRL_HI:dac_regs_pkg::CTRL_LO] = sys_q.ctrl;
                dac_regs_pkg::ADDR_CLEAR_VAL:
                    sys_d.read_word[dac_regs_pkg::DATA_HI:dac_regs_pkg::DATA_LO] = sys_q.clear_value;
                default: ;
            endcase
        end

        // clear wins when both actions arrive in one frame
        if (soft_clear) begin
            sys_d.active = sys_q.clear_value; // [R10]
            sys_d.update = 1'b1;
        end else if (soft_load) begin
            sys_d.active = sys_d.pending; // [R09]
            sys_d.update = 1'b1;
        end

        // pins act as levels; clear pin has priority over load pin
        if (clear_pin_low) begin
            sys_d.active = sys_q.clear_value;
            sys_d.update = (sys_q.active != sys_q.clear_value) | sys_d.update;
        end else if (load_pin_low) begin
            sys_d.active = sys_d.pending;
            sys_d.update = (sys_q.active != sys_d.pending) | sys_d.update;
        end

        if (frame_end && w[dac_regs_pkg::RW_BIT] == dac_regs_pkg::RW_WRITE &&
            addr == dac_regs_pkg::ADDR_SOFT_ACT && w[dac_regs_pkg::SOFT_RESET_BIT]) begin
            // power-on values on the system side except the pin synchronisers; update pulses high [R11]
            sys_d.pending     = dac_regs_pkg::DAC_RESET;
            sys_d.active      = dac_regs_pkg::DAC_RESET;
            sys_d.clear_value = dac_regs_pkg::CLEAR_RESET;
            sys_d.ctrl        = dac_regs_pkg::CTRL_RESET;
            sys_d.read_word   = '0;
            sys_d.update      = 1'b1;
        end

        // output code is offset binary; twos complement flips the msb [R01] [R10]
        sys_d.coding   = sys_d.ctrl[dac_regs_pkg::CTRL_CODING];
        sys_d.dac_code = (sys_d.coding == dac_regs_pkg::CODING_TWOS) ?
                         (sys_d.active ^ dac_regs_pkg::MSB_FLIP) : sys_d.active;
        sys_d.sdo_oe   = ~sys_q.pins.sync[dac_regs_pkg::PIN_SYNC_N] &
                         ~sys_d.ctrl[dac_regs_pkg::CTRL_SDO_DIS]; // [R02]
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sys_q                  <= '0;
            sys_q.pins.meta        <= dac_regs_pkg::PINS_IDLE;
            sys_q.pins.sync        <= dac_regs_pkg::PINS_IDLE;
            sys_q.pins.sync_n_prev <= 1'b1;
            sys_q.pending          <= dac_regs_pkg::DAC_RESET;
            sys_q.active           <= dac_regs_pkg::DAC_RESET;
            sys_q.clear_value      <= dac_regs_pkg::CLEAR_RESET;
            sys_q.ctrl             <= dac_regs_pkg::CTRL_RESET;
            sys_q.dac_code         <= DAC_CODE_AT_RESET;
            sys_q.coding           <= dac_regs_pkg::CODING_TWOS;
        end else begin
            sys_q <= sys_d;
        end
    end

    assign serial_data_out    = sdo_q;
    assign serial_data_oe_out = sys_q.sdo_oe;
    assign dac_code_out       = sys_q.dac_code;
    assign dac_update_out     = sys_q.update;
    assign coding_select_out  = sys_q.coding;

endmodule

// ===== verification/dac_soft_regs_chk.sv
`timescale 1ns/100ps
module dac_soft_regs_chk (
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        serial_clk_in,
    input wire logic        frame_sync_n_in,
    input wire logic        serial_data_in,
    input wire logic        load_output_n_in,
    input wire logic        clear_to_code_n_in,
    input wire logic        serial_data_out,
    input wire logic        serial_data_oe_out,
    input wire logic [15:0] dac_code_out,
    input wire logic        dac_update_out,
    input wire logic        coding_select_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // no frame and no pin activity: nothing may move
    logic quiet;
    assign quiet = frame_sync_n_in & load_output_n_in & clear_to_code_n_in;
    reset_values_a: assert property ($fell(sys_rst_in) |->
        dac_code_out == 16'h8000 && !coding_select_out && !serial_data_oe_out) else $error("bad reset values");
    code_hold_a: assert property (quiet [*8] |=> $stable(dac_code_out)) else $error("code moved idle");
    update_idle_a: assert property (quiet [*8] |=> !dac_update_out) else $error("update while idle");
    update_pulse_a: assert property (dac_update_out |=> !dac_update_out) else $error("update too long");
    coding_hold_a: assert property (quiet [*8] |=> $stable(coding_select_out)) else $error("coding moved");
    oe_idle_a: assert property (frame_sync_n_in [*8] |=> !serial_data_oe_out) else $error("oe outside frame");
    oe_rise_a: assert property ($rose(serial_data_oe_out) |-> !$past(frame_sync_n_in, 2))
        else $error("oe rose without frame");
    oe_fall_a: assert property ($fell(serial_data_oe_out) |-> $past(frame_sync_n_in, 2))
        else $error("oe fell inside frame");
endmodule
bind dac_soft_regs dac_soft_regs_chk chk (.sys_clk_in, .sys_rst_in, .serial_clk_in, .frame_sync_n_in,
    .serial_data_in, .load_output_n_in, .clear_to_code_n_in, .serial_data_out, .serial_data_oe_out,
    .dac_code_out, .dac_update_out, .coding_select_out);

// ===== verification/serial_host.sv
`timescale 1ns/100ps
module serial_host (
    output logic      sclk_out,
    output logic      sync_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic oe_in
);
    logic last = 1'b0;
    initial begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // msb first, bit 23 picks direction; callers pass zeros in reserved bits except the ignored low four of the clear value write 3ABCDF
    task automatic xfer(input logic [23:0] w, output logic [23:0] rd, output logic oe_seen);
        rd = 24'h000000;
        oe_seen = 1'b0;
        #7 sync_n_out = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            #8 sdi_out = w[i];
            #7 sclk_out = 1'b1;
            // a released line gives no stale value, so it toggles
            last = oe_in ? sdo_in : ~last;
            if (i < 23) rd[i + 1] = last;
            if (i == 12) oe_seen = oe_in;
            #15 sclk_out = 1'b0;
        end
        #8 sync_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule

// ===== verification/dac_soft_regs_tb.sv
`timescale 1ns/100ps
module dac_soft_regs_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        load_n = 1'b1;
    logic        clr_n = 1'b1;
    logic        sclk, sync_n, sdi, sdo, oe, upd, coding, oe_seen;
    logic [15:0] code;
    logic [23:0] rd;
    int          n_errors = 0;
    int          compares = 0;
    int          n_upd = 0;
    always #2 clk = ~clk;
    // count one-cycle update pulses seen on the converter side
    always @(posedge clk) begin
        if (upd === 1'b1) n_upd++;
    end
    dac_soft_regs uut (.sys_clk_in(clk), .sys_rst_in(rst), .serial_clk_in(sclk), .frame_sync_n_in(sync_n),
        .serial_data_in(sdi), .load_output_n_in(load_n), .clear_to_code_n_in(clr_n), .serial_data_out(sdo),
        .serial_data_oe_out(oe), .dac_code_out(code), .dac_update_out(upd), .coding_select_out(coding));
    serial_host host (.sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi), .sdo_in(sdo), .oe_in(oe));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // waits past the sync and decode latency before anyone samples
    task automatic xf(input logic [23:0] w);
        host.xfer(w, rd, oe_seen);
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic pins(input logic ld, input logic cl);
        @(posedge clk);
        load_n <= ld;
        clr_n <= cl;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("code", 24'h008000, {8'h00, code});
        xf(24'h112340);
        chk("code", 24'h008000, {8'h00, code});
        xf(24'h400001);
        chk("code", 24'h009234, {8'h00, code});
        chk("oe", 24'h000001, {23'h0, oe_seen});
        chk("update", 24'h000001, n_upd[23:0]);
        xf(24'h200010);
        chk("coding", 24'h000001, {23'h0, coding});
        xf(24'h400001);
        chk("code", 24'h001234, {8'h00, code});
        $display("test load done");
        xf(24'h3ABCDF);
        xf(24'h400002);
        chk("code", 24'h00ABCD, {8'h00, code});
        xf(24'hB00000);
        xf(24'h800000);
        chk("readback", 24'hBABCD0, {rd[23:1], 1'b0});
        xf(24'hC00000);
        xf(24'h800000);
        chk("readback", 24'hC00000, {rd[23:1], 1'b0});
        $display("test clear done");
        pins(1'b0, 1'b1);
        xf(24'h400002);
        pins(1'b1, 1'b1);
        chk("code", 24'h001234, {8'h00, code});
        pins(1'b1, 1'b0);
        xf(24'h400001);
        pins(1'b1, 1'b1);
        chk("code", 24'h00ABCD, {8'h00, code});
        $display("test pins done");
        xf(24'h200030);
        xf(24'h400004);
        chk("oe", 24'h000000, {23'h0, oe_seen});
        chk("code", 24'h008000, {8'h00, code});
        chk("coding", 24'h000000, {23'h0, coding});
        xf(24'hB00000);
        xf(24'h800000);
        chk("readback", 24'hB00000, {rd[23:1], 1'b0});
        chk("oe", 24'h000001, {23'h0, oe_seen});
        $display("test reset done");
        end_of_test();
    end
endmodule
